// >>> design/uer_pkg.sv
package uer_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] UER_OFS_FLAGS = 8'h00;
  localparam logic [7:0] UER_OFS_ENABLE = 8'h04;
  localparam logic [7:0] UER_OFS_DESC = 8'h08;
  localparam logic [7:0] UER_OFS_STREAM = 8'h0C;
  // error bit positions, shared by flag and enable registers
  localparam int UER_BIT_PID = 0;
  localparam int UER_BIT_TOKCRC = 1;
  localparam int UER_BIT_DATCRC = 2;
  localparam int UER_BIT_FSIZE = 3;
  localparam int UER_BIT_TURN = 4;
  localparam int UER_BIT_STUFF = 7;
  localparam logic [7:0] UER_IMPL_MASK = 8'h9F;
  localparam logic [7:0] UER_RESET = 8'h00;
  // descriptor status bits and the stream address marker
  localparam int UER_DS_KEEP = 5;
  localparam int UER_DS_ADDRESS_INCREMENT_DISABLE = 4;
  localparam logic [15:0] UER_STREAM_ADDR = 16'hFFFF;
  localparam int UER_EP_NUM = 16;

  // apb request from the master
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uer_apb_s;

  // streaming port data beat
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic [7:0] data;
  } uer_beat_s;
endpackage : uer_pkg

// >>> design/uer_top.sv
`timescale 1ns/1ns
module uer_top
  import uer_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] err_event_i,
  input wire logic [3:0] xfer_ep_i,
  input wire logic xfer_valid_i,
  input wire logic [7:0] xfer_data_i,
  output logic [7:0] xfer_data_o,
  output logic xfer_to_ram_o,
  output logic [15:0] ram_addr_o,
  output logic [7:0] stream_data_o,
  output logic stream_valid_o,
  output logic [3:0] stream_ep_o,
  input wire logic [7:0] stream_data_i,
  output logic err_irq_o
);

  // descriptor of one endpoint: address and status bits
  function automatic logic is_stream(input logic [15:0] a, input logic k,
                                     input logic d);
    is_stream = (a == UER_STREAM_ADDR) && k && d;
  endfunction : is_stream

  uer_apb_s req;
  logic [7:0] flag_q, flag_d;
  logic [7:0] en_q, en_d;
  logic [15:0] dadr_q [UER_EP_NUM];
  logic [7:0] dstat_q [UER_EP_NUM];
  logic [3:0] dsel_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic irq_q;
  logic [7:0] xdo_q;
  logic xram_q;
  logic [15:0] raddr_q;
  uer_beat_s sbeat_q;

  // bus request decode
  assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
  wire acc = req.sel && req.enable && !ready_q;
  wire wr = req.sel && req.enable && ready_q && req.write; // commit at ready
  wire hit_flag = req.addr == UER_OFS_FLAGS;
  wire hit_en = req.addr == UER_OFS_ENABLE;
  wire hit_desc = req.addr == UER_OFS_DESC;
  wire hit_sel = req.addr == UER_OFS_STREAM;
  wire mapped = hit_flag || hit_en || hit_desc || hit_sel;

  // flags: events set (set wins), write one clears
  wire [7:0] clr = (wr && hit_flag) ? req.wdata[7:0] : 8'h00;
  assign flag_d = ((flag_q & ~clr) | err_event_i) & UER_IMPL_MASK;

  // enables: unimplemented bits forced to zero
  assign en_d = (wr && hit_en) ? (req.wdata[7:0] & UER_IMPL_MASK)
                               : en_q;

  // combined error interrupt from enabled flags only
  wire [7:0] gated = flag_q & en_q;
  wire irq_d = |gated;

  // routing decision for the current endpoint
  wire [15:0] cur_adr = dadr_q[xfer_ep_i];
  wire [7:0] cur_st = dstat_q[xfer_ep_i];
  wire route_stream = is_stream(cur_adr, cur_st[UER_DS_KEEP],
                                cur_st[UER_DS_ADDRESS_INCREMENT_DISABLE]);
  wire [15:0] next_adr = cur_st[UER_DS_ADDRESS_INCREMENT_DISABLE] ? cur_adr
                       : 16'(cur_adr + 16'h0001);

  // read mux
  wire [31:0] rd_d = hit_flag ? {24'h0, flag_q}
                   : hit_en ? {24'h0, en_q}
                   : hit_desc ? {8'h0, dstat_q[dsel_q], dadr_q[dsel_q]}
                   : hit_sel ? {28'h0, dsel_q} : 32'h0;

  // error flags, enables and interrupt
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_q <= UER_RESET;
      en_q <= UER_RESET;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      dsel_q <= 4'h0;
    end else begin
      ready_q <= acc;
      slverr_q <= acc && !mapped;
      if (acc && !req.write) rdata_q <= rd_d;
      if (wr && hit_sel) dsel_q <= req.wdata[3:0];
    end
  end

  // descriptor table, written by software, advanced by the engine
  generate
    for (genvar i = 0; i < UER_EP_NUM; i++) begin : g_desc
      wire act = xfer_valid_i && (xfer_ep_i == 4'(i)) && !route_stream;
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          dadr_q[i] <= 16'h0000;
          dstat_q[i] <= 8'h00;
        end else if (wr && hit_desc && dsel_q == 4'(i)) begin
          dadr_q[i] <= req.wdata[15:0];
          dstat_q[i] <= req.wdata[23:16];
        end else if (act) begin
          dadr_q[i] <= next_adr;
        end
      end
    end
  endgenerate

  // data path: ram or streaming port, no cpu per byte
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xdo_q <= 8'h00;
      xram_q <= 1'b0;
      raddr_q <= 16'h0000;
      sbeat_q <= '0;
    end else begin
      xram_q <= xfer_valid_i && !route_stream;
      raddr_q <= cur_adr;
      sbeat_q.valid <= xfer_valid_i && route_stream;
      sbeat_q.ep <= xfer_ep_i;
      sbeat_q.data <= xfer_data_i;
      xdo_q <= route_stream ? stream_data_i : 8'h00;
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = slverr_q;
  assign err_irq_o = irq_q;
  assign xfer_data_o = xdo_q;
  assign xfer_to_ram_o = xram_q;
  assign ram_addr_o = raddr_q;
  assign stream_valid_o = sbeat_q.valid;
  assign stream_ep_o = sbeat_q.ep;
  assign stream_data_o = sbeat_q.data;

  // assertions
  property p_irq_turn;
    @(posedge clk_i) disable iff (srst_i)
    (flag_q[UER_BIT_TURN] && en_q[UER_BIT_TURN]) |=> err_irq_o;
  endproperty
  a_irq_turn: assert property (p_irq_turn) else $error("turn irq");
  property p_tok_block;
    @(posedge clk_i) disable iff (srst_i)
    ((flag_q & en_q) == 8'h00) |=> !err_irq_o;
  endproperty
  a_tok_block: assert property (p_tok_block) else $error("leak");
  property p_res_zero;
    @(posedge clk_i) disable iff (srst_i) (en_q[6:5] == 2'b00)
      && (flag_q[6:5] == 2'b00);
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("resv");
  property p_or;
    @(posedge clk_i) disable iff (srst_i)
    (|(flag_q & en_q)) |=> err_irq_o;
  endproperty
  a_or: assert property (p_or) else $error("or");
  property p_poll;
    @(posedge clk_i) disable iff (srst_i)
    err_event_i[UER_BIT_TOKCRC] |=> flag_q[UER_BIT_TOKCRC];
  endproperty
  a_poll: assert property (p_poll) else $error("flag lost");
  property p_stream;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && route_stream) |=> stream_valid_o && !xfer_to_ram_o;
  endproperty
  a_stream: assert property (p_stream) else $error("route");
  property p_ram;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && !route_stream) |=> xfer_to_ram_o && !stream_valid_o;
  endproperty
  a_ram: assert property (p_ram) else $error("ram route");
  property p_noinc;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && route_stream && !(wr && hit_desc))
      |=> (dadr_q[stream_ep_o] == $past(cur_adr));
  endproperty
  a_noinc: assert property (p_noinc) else $error("addr moved");
  property p_rst_en;
    @(posedge clk_i) srst_i |=> (en_q == 8'h00);
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("en reset");

  // turnaround flag with nothing enabled stays off the interrupt
  property p_to_off;
    @(posedge clk_i) disable iff (srst_i)
    (flag_q[UER_BIT_TURN] && ((flag_q & en_q) == 8'h00)) |=> !err_irq_o;
  endproperty
  a_to_off: assert property (p_to_off) else $error("to leak");

  // enabled token crc flag reaches the interrupt
  property p_tok_pass;
    @(posedge clk_i) disable iff (srst_i)
    (flag_q[UER_BIT_TOKCRC] && en_q[UER_BIT_TOKCRC]) |=> err_irq_o;
  endproperty
  a_tok_pass: assert property (p_tok_pass) else $error("tok");

  // enable writes keep only the implemented bits
  property p_en_wr;
    @(posedge clk_i) disable iff (srst_i)
    (wr && hit_en) |=> (en_q == (UER_IMPL_MASK & $past(req.wdata[7:0])));
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("en write");

  // every event on an implemented bit sets its flag, even against a clear
  property p_set_all;
    @(posedge clk_i) disable iff (srst_i)
    (|err_event_i) |=> ((flag_q & $past(err_event_i))
      == ($past(err_event_i) & UER_IMPL_MASK));
  endproperty
  a_set_all: assert property (p_set_all) else $error("set");

  // flags and interrupt clear on reset as well
  property p_rst_flag;
    @(posedge clk_i) srst_i |=> ((flag_q == UER_RESET) && !err_irq_o);
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("rst");

  // a streamed beat carries the engine byte and endpoint out
  property p_beat_out;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && route_stream)
      |=> ((stream_data_o == $past(xfer_data_i))
      && (stream_ep_o == $past(xfer_ep_i)));
  endproperty
  a_beat_out: assert property (p_beat_out) else $error("beat");

  // a streamed beat returns the external byte to the engine
  property p_beat_in;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && route_stream)
      |=> (xfer_data_o == $past(stream_data_i));
  endproperty
  a_beat_in: assert property (p_beat_in) else $error("beat in");

  // a descriptor write lands in the selected endpoint
  property p_desc_wr;
    @(posedge clk_i) disable iff (srst_i)
    (wr && hit_desc) |=> (dadr_q[dsel_q] == $past(req.wdata[15:0]));
  endproperty
  a_desc_wr: assert property (p_desc_wr) else $error("desc");

  // only the ffff marker opens the streaming port
  property p_mark;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && (cur_adr != UER_STREAM_ADDR)) |=> !stream_valid_o;
  endproperty
  a_mark: assert property (p_mark) else $error("marker");

  // without the keep bit the beat never streams
  property p_keep_off;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && !cur_st[UER_DS_KEEP]) |=> !stream_valid_o;
  endproperty
  a_keep_off: assert property (p_keep_off) else $error("keep");

  // ram beats advance the address unless increment is off
  property p_inc;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && !route_stream && !cur_st[UER_DS_ADDRESS_INCREMENT_DISABLE]
      && !(wr && hit_desc))
      |=> (dadr_q[stream_ep_o] == 16'($past(cur_adr) + 16'h0001));
  endproperty
  a_inc: assert property (p_inc) else $error("addr inc");

  // ram beats present the address they used
  property p_ram_adr;
    @(posedge clk_i) disable iff (srst_i)
    (xfer_valid_i && !route_stream) |=> (ram_addr_o == $past(cur_adr));
  endproperty
  a_ram_adr: assert property (p_ram_adr) else $error("ram addr");

  // nothing but a routed engine beat reaches the port
  property p_port_src;
    @(posedge clk_i) disable iff (srst_i)
    stream_valid_o |-> $past(xfer_valid_i && route_stream);
  endproperty
  a_port_src: assert property (p_port_src) else $error("port");
endmodule : uer_top

// >>> testbench/uer_ext_model.sv
`timescale 1ns/1ns
// external fifo behind the port; next byte per beat
module uer_ext_model (
  input wire logic clk_i,
  input wire logic beat_i,
  output logic [7:0] byte_o
);
  // advance once a beat is taken
  logic [7:0] next_q = 8'h5A;
  always @(posedge clk_i) if (beat_i) next_q <= next_q + 8'h01;
  assign byte_o = next_q;
endmodule : uer_ext_model

// >>> testbench/usb_error_enable_and_endpoint_routing_tb.sv
`timescale 1ns/1ns
module usb_error_enable_and_endpoint_routing_tb;
  import uer_pkg::*;
  logic clk_i = 0, srst_i = 1, pready_o, pslverr_o, xfer_to_ram_o;
  logic stream_valid_o, err_irq_o;
  logic [7:0] err_event_i = 0, xfer_data_o, stream_data_o, stream_data_i;
  logic [3:0] stream_ep_o;
  logic [15:0] ram_addr_o;
  logic [31:0] prdata_o, rd;
  uer_apb_s q = '0;
  uer_beat_s b = '0;
  int errors = 0, checks_done = 0;
  // block and external fifo
  uer_top DUT (.clk_i, .srst_i, .psel_i(q.sel), .penable_i(q.enable),
    .pwrite_i(q.write), .paddr_i(q.addr), .pwdata_i(q.wdata), .prdata_o,
    .pready_o, .pslverr_o, .err_event_i, .xfer_ep_i(b.ep),
    .xfer_valid_i(b.valid), .xfer_data_i(b.data), .xfer_data_o,
    .xfer_to_ram_o, .ram_addr_o, .stream_data_o, .stream_valid_o,
    .stream_ep_o, .stream_data_i, .err_irq_o);
  uer_ext_model ext (.clk_i, .beat_i(stream_valid_o), .byte_o(stream_data_i));
  // clock and watchdog
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      errors++;
    end
  endtask : chk
  // one apb transfer, waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    @(posedge clk_i);
    q <= '{1, 0, w, a, d};
    @(posedge clk_i);
    q.enable <= 1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1);
    rd = prdata_o;
    chk("ready", 1, pready_o);
    chk("slverr", e, pslverr_o);
    q <= '0;
  endtask : apb
  // event pulse, then the two-edge irq latency
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    err_event_i <= v;
    @(posedge clk_i);
    err_event_i <= 0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse
  // reset value, implemented bits, clearing, unmapped place
  task automatic t_regs();
    apb(0, UER_OFS_ENABLE, 0, 0);
    chk("enable rst", UER_RESET, rd);
    apb(1, UER_OFS_ENABLE, 32'hFFFF_FFFF, 0);
    apb(0, UER_OFS_ENABLE, 0, 0);
    chk("enable", UER_IMPL_MASK, rd);
    pulse(8'hFF);
    chk("irq all", 1, err_irq_o);
    apb(0, UER_OFS_FLAGS, 0, 0);
    chk("flags", UER_IMPL_MASK, rd);
    apb(1, UER_OFS_FLAGS, 32'h0000_00FF, 0);
    apb(0, UER_OFS_FLAGS, 0, 0);
    chk("flags clr", 0, rd);
    apb(1, 8'h10, 32'h0000_00FF, 1);
    apb(0, 8'h10, 0, 1);
    chk("unmapped", 0, rd);
  endtask : t_regs
  // each error bit alone, masked with all others on, then enabled
  task automatic t_irq();
    int bits [6] = '{UER_BIT_PID, UER_BIT_TOKCRC, UER_BIT_DATCRC,
                     UER_BIT_FSIZE, UER_BIT_TURN, UER_BIT_STUFF};
    logic [7:0] m;
    foreach (bits[i]) begin
      m = 8'h01 << bits[i];
      for (int en = 0; en < 2; en++) begin
        apb(1, UER_OFS_ENABLE, en ? m : UER_IMPL_MASK & ~m, 0);
        pulse(m);
        chk("irq", en, err_irq_o);
        apb(0, UER_OFS_FLAGS, 0, 0);
        chk("flag", m, rd);
        apb(1, UER_OFS_FLAGS, m, 0);
        pulse(0);
        chk("irq clr", 0, err_irq_o);
      end
    end
  endtask : t_irq
  // one beat from the engine; check where it went
  task automatic beat(input logic [3:0] e, input logic s,
                      input logic [15:0] a);
    logic [7:0] x;
    @(posedge clk_i);
    b <= '{1, e, {e, 4'hA}};
    @(posedge clk_i);
    x = stream_data_i;
    b <= '0;
    #1;
    chk("route", {s, !s}, {stream_valid_o, xfer_to_ram_o});
    if (s) begin
      chk("beat", {e, e, 4'hA, x}, {stream_ep_o, stream_data_o,
          xfer_data_o});
    end else begin
      chk("ram addr", a, ram_addr_o);
    end
  endtask : beat
  // stream only with ffff, keep and address_increment_disable; isochronous use assumed
  task automatic t_route();
    apb(1, UER_OFS_STREAM, 3, 0);
    apb(1, UER_OFS_DESC, 32'h0030_FFFF, 0);
    beat(3, 1, 0);
    beat(3, 1, 0);
    apb(1, UER_OFS_STREAM, 2, 0);
    apb(1, UER_OFS_DESC, 32'h0000_0100, 0);
    beat(2, 0, 16'h0100);
    beat(2, 0, 16'h0101);
    apb(1, UER_OFS_DESC, 32'h0010_0200, 0);
    beat(2, 0, 16'h0200);
    beat(2, 0, 16'h0200);
    apb(1, UER_OFS_DESC, 32'h0010_FFFF, 0);
    beat(2, 0, 16'hFFFF);
    beat(3, 1, 0);
  endtask : t_route
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // reset, then the scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    t_regs();
    t_irq();
    t_route();
    end_sim();
  end
endmodule : usb_error_enable_and_endpoint_routing_tb
